//--- hdl/ecp_pkg.sv
// Operation
// - mode is a three-bit field in the top of the extended control register.
// - mode codes 000,001,010,011,110,111 select standard, byte, fifo, ecp, test, config.
// - first base offset 0 is data in 000/001, address/RLE fifo port in 011.
// - second base offset 0 is compat, ecp data, test fifo, or config A by mode.
// - status at first base +1 and control at +2 reachable in every mode.
// - data register resets to 0, captured on IOW# rise, driven uninverted to PD.
// - bytes to the address/RLE port are queued tagged and sent automatically.
// - status bit 7 reads inverse of Busy.
// - status bits 6..3 read nAck, PError, Select, nFault uninverted.
// - status bits 2..0 always read one.
// - control bits 7..6 read one and ignore writes.
// - control bits 5..0 clear to zero during reset.
// - direction bit sets PD in/out outside 000/010; forced zero in 000.
// - with control bit 4 set, nAck rising edge raises an interrupt.
// - control bit 3 drives SelectIn inverted, bit 2 drives nInit straight.
// - control bit 1 drives nAutoFd inverted, bit 0 drives nStrobe inverted, except in fifo modes 010/011.
// - forward transfers handshake nStrobe against Busy.
// - reverse: nAutoFd low requests a byte, peripheral answers with nAck.
// - forward nAutoFd marks command or data; reverse Busy marks it.
// - nInit low reverses bus; peripheral drives only with nInit low. PD direction here follows control bit 5 outside 000/010 (forward there), not nInit.
// - in ecp mode nSelectIn is held high.
package ecp_pkg;
   // ---------------------------------------------
   // register offsets and modes
   // ---------------------------------------------
   localparam logic [1:0] OFS_DATA = 2'h0;
   localparam logic [1:0] OFS_STAT = 2'h1;
   localparam logic [1:0] OFS_CTRL = 2'h2;
   localparam logic [2:0] MODE_STD = 3'h0;
   localparam logic [2:0] MODE_BYTE = 3'h1;
   localparam logic [2:0] MODE_COMPAT_FIFO_PORT = 3'h2;
   localparam logic [2:0] MODE_ECP = 3'h3;
   localparam logic [2:0] MODE_TEST = 3'h6;
   localparam logic [2:0] MODE_CFG = 3'h7;
   // ---------------------------------------------
   // field positions and fixed values
   // ---------------------------------------------
   localparam int ECR_MODE_LO = 5;
   localparam int ECR_NERR = 4;
   localparam int DCR_DIR = 5;
   localparam int DCR_IRQE = 4;
   localparam int DCR_SLIN = 3;
   localparam int DCR_INIT = 2;
   localparam int DCR_AFD = 1;
   localparam int DCR_STB = 0;
   localparam logic [1:0] DCR_TOP_ONES = 2'h3;
   localparam logic [2:0] DSR_LOW_ONES = 3'h7;
   localparam logic [7:0] CFGA_VALUE = 8'h10;
   localparam logic [7:0] UNMAPPED_RD = 8'hff;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [5:0] DCR_RST = 6'h00;
   localparam logic [4:0] ECR_RST = 5'h00;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_AW = 4;
   // ---------------------------------------------
   // types
   // ---------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_FSET = 3'h1,
      ST_FSTB = 3'h3,
      ST_FREL = 3'h2,
      ST_RREQ = 3'h6,
      ST_RACK = 3'h7
   } ecp_state_e;
   typedef struct packed {
      logic busy;
      logic nAck;
      logic pError;
      logic select;
      logic nFault;
      logic [7:0] pd;
   } ecp_pins_s;
   typedef struct packed {
      logic iowN;
      logic iorN;
      logic base1SelN;
      logic base2SelN;
      logic [1:0] addr;
      logic [7:0] data;
   } ecp_bus_s;
   typedef struct packed {
      logic tag;
      logic [7:0] data;
   } ecp_entry_s;
endpackage

//--- hdl/ecp_parallel_port.sv
`timescale 1ns/1ps
module ecp_parallel_port (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   // host i/o bus
   input wire ecp_pkg::ecp_bus_s hostBus,
   output logic [7:0] hostRdData,
   output logic hostRdOe,
   output logic irqReq,
   // printer pins
   input wire ecp_pkg::ecp_pins_s pinIn,
   output logic [7:0] pdOut,
   output logic pdOe,
   output logic nStrobe,
   output logic nAutoFd,
   output logic nInit,
   output logic nSelectIn
);
   // ---------------------------------------------
   // input synchronisers
   // ---------------------------------------------
   ecp_pkg::ecp_bus_s busA_r, busS_r;
   ecp_pkg::ecp_pins_s pinA_r, pinS_r;
   logic iowD_r, iorD_r, nAckD_r, nFaultD_r;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busA_r <= '1;
         busS_r <= '1;
         pinA_r <= '1;
         pinS_r <= '1;
         iowD_r <= 1'b1;
         iorD_r <= 1'b1;
         nAckD_r <= 1'b1;
         nFaultD_r <= 1'b1;
      end else if (clkEn) begin
         busA_r <= hostBus;
         busS_r <= busA_r;
         pinA_r <= pinIn;
         pinS_r <= pinA_r;
         iowD_r <= busS_r.iowN;
         iorD_r <= busS_r.iorN;
         nAckD_r <= pinS_r.nAck;
         nFaultD_r <= pinS_r.nFault;
      end
   end

   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   logic wrStb, rdStb, sel1, sel2;
   logic [2:0] mode;
   logic [7:0] wd;
   logic [1:0] ofs;
   logic [5:0] dcr_r;
   logic [4:0] ecrLow_r;
   logic [7:0] data_r;
   logic dirEff, fifoMode;

   // write data is taken as IOW# rises, read starts as IOR# falls
   assign wrStb = busS_r.iowN & ~iowD_r;
   assign rdStb = ~busS_r.iorN & iorD_r;
   assign sel1 = ~busS_r.base1SelN;
   assign sel2 = ~busS_r.base2SelN;
   assign wd = busS_r.data;
   assign ofs = busS_r.addr;
   assign fifoMode = (mode == ecp_pkg::MODE_COMPAT_FIFO_PORT) || (mode == ecp_pkg::MODE_ECP);
   // modes 000 and 010 always drive forward
   assign dirEff = (mode == ecp_pkg::MODE_STD || mode == ecp_pkg::MODE_COMPAT_FIFO_PORT) ?
                   1'b0 : dcr_r[ecp_pkg::DCR_DIR];

   logic wrData, wrAfifo, wrDfifo, wrCtrl, wrEcr;
   logic rdAfifoOrD, rdTest;
   assign wrData = wrStb & sel1 & (ofs == ecp_pkg::OFS_DATA) &
                   (mode == ecp_pkg::MODE_STD || mode == ecp_pkg::MODE_BYTE);
   assign wrAfifo = wrStb & sel1 & (ofs == ecp_pkg::OFS_DATA) &
                    (mode == ecp_pkg::MODE_ECP) & ~dirEff;
   assign wrDfifo = wrStb & sel2 & (ofs == ecp_pkg::OFS_DATA) &
                    (((mode == ecp_pkg::MODE_COMPAT_FIFO_PORT || mode == ecp_pkg::MODE_ECP) & ~dirEff)
                     | (mode == ecp_pkg::MODE_TEST));
   assign wrCtrl = wrStb & sel1 & (ofs == ecp_pkg::OFS_CTRL);
   assign wrEcr = wrStb & sel2 & (ofs == ecp_pkg::OFS_CTRL);
   assign rdAfifoOrD = rdStb & sel2 & (ofs == ecp_pkg::OFS_DATA) &
                       (mode == ecp_pkg::MODE_ECP) & dirEff;
   assign rdTest = rdStb & sel2 & (ofs == ecp_pkg::OFS_DATA) &
                   (mode == ecp_pkg::MODE_TEST);

   // ---------------------------------------------
   // fifo shared by all fifo modes
   // ---------------------------------------------
   ecp_pkg::ecp_entry_s mem [ecp_pkg::FIFO_DEPTH];
   logic [ecp_pkg::FIFO_AW-1:0] wrPtr_r, rdPtr_r;
   logic [ecp_pkg::FIFO_AW:0] count_r;
   logic full, empty, push, pop, hostPush, hostPop, revPush, fwdPop;
   ecp_pkg::ecp_entry_s pushEntry, head;
   logic [7:0] lastRd_r;

   assign full = (count_r == (ecp_pkg::FIFO_AW+1)'(ecp_pkg::FIFO_DEPTH));
   assign empty = (count_r == '0);
   assign head = mem[rdPtr_r];
   // a full fifo drops further writes
   assign hostPush = (wrAfifo | wrDfifo) & ~full;
   assign hostPop = (rdAfifoOrD | rdTest) & ~empty;
   assign push = hostPush | revPush;
   assign pop = hostPop | fwdPop;

   always_comb begin
      pushEntry.tag = wrAfifo;
      pushEntry.data = wd;
      if (revPush) begin
         pushEntry.tag = ~pinS_r.busy;
         pushEntry.data = pinS_r.pd;
      end
   end

   always_ff @(posedge mclk) begin
      if (clkEn && push) begin
         mem[wrPtr_r] <= pushEntry;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         count_r <= '0;
      end else if (clkEn) begin
         if (mode == ecp_pkg::MODE_STD) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
         end else begin
            if (push) begin
               wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
               rdPtr_r <= rdPtr_r + 1'b1;
            end
            if (push && !pop) begin
               count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
               count_r <= count_r - 1'b1;
            end
         end
      end
   end

   // an empty test fifo answers with the last byte read
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lastRd_r <= ecp_pkg::DATA_RST;
      end else if (clkEn && hostPop) begin
         lastRd_r <= head.data;
      end
   end

   // ---------------------------------------------
   // registers
   // ---------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         data_r <= ecp_pkg::DATA_RST;
      end else if (clkEn && wrData) begin
         data_r <= wd;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dcr_r <= ecp_pkg::DCR_RST;
      end else if (clkEn) begin
         if (wrCtrl) begin
            dcr_r <= wd[5:0];
         end
         if (mode == ecp_pkg::MODE_STD) begin
            dcr_r[ecp_pkg::DCR_DIR] <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= ecp_pkg::MODE_STD;
         ecrLow_r <= ecp_pkg::ECR_RST;
      end else if (clkEn && wrEcr) begin
         mode <= wd[7:ecp_pkg::ECR_MODE_LO];
         ecrLow_r <= wd[4:0];
      end
   end

   // ---------------------------------------------
   // interrupt pulses
   // ---------------------------------------------
   logic ackIrq, faultIrq, errEnFall;
   assign ackIrq = dcr_r[ecp_pkg::DCR_IRQE] & pinS_r.nAck & ~nAckD_r;
   // re-enabling while nFault is low also fires
   assign errEnFall = wrEcr & ecrLow_r[ecp_pkg::ECR_NERR] & ~wd[ecp_pkg::ECR_NERR]
                      & ~pinS_r.nFault;
   assign faultIrq = (mode == ecp_pkg::MODE_ECP) & ~dirEff &
                     ((~ecrLow_r[ecp_pkg::ECR_NERR] & ~pinS_r.nFault & nFaultD_r)
                      | errEnFall);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irqReq <= 1'b0;
      end else if (clkEn) begin
         irqReq <= ackIrq | faultIrq;
      end
   end

   // ---------------------------------------------
   // handshake engine
   // ---------------------------------------------
   ecp_pkg::ecp_state_e state_r;
   ecp_pkg::ecp_entry_s outEntry_r;
   logic canFwd, canRev;

   assign canFwd = fifoMode & ~dirEff & ~empty & ~hostPop;
   assign canRev = (mode == ecp_pkg::MODE_ECP) & dirEff & ~full & ~hostPush;
   assign fwdPop = clkEn & (state_r == ecp_pkg::ST_IDLE) & canFwd;
   assign revPush = (state_r == ecp_pkg::ST_RREQ) & ~pinS_r.nAck &
                    (mode == ecp_pkg::MODE_ECP);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ecp_pkg::ST_IDLE;
         outEntry_r <= '0;
      end else if (clkEn) begin
         if (!fifoMode) begin
            // leaving a fifo mode drops any handshake in flight
            state_r <= ecp_pkg::ST_IDLE;
         end else begin
            case (state_r)
               ecp_pkg::ST_IDLE: begin
                  if (canFwd) begin
                     outEntry_r <= head;
                     state_r <= ecp_pkg::ST_FSET;
                  end else if (canRev) begin
                     state_r <= ecp_pkg::ST_RREQ;
                  end
               end
               ecp_pkg::ST_FSET: begin
                  if (!pinS_r.busy) begin
                     state_r <= ecp_pkg::ST_FSTB;
                  end
               end
               ecp_pkg::ST_FSTB: begin
                  if (pinS_r.busy) begin
                     state_r <= ecp_pkg::ST_FREL;
                  end
               end
               ecp_pkg::ST_FREL: begin
                  if (!pinS_r.busy) begin
                     state_r <= ecp_pkg::ST_IDLE;
                  end
               end
               ecp_pkg::ST_RREQ: begin
                  if (!pinS_r.nAck) begin
                     state_r <= ecp_pkg::ST_RACK;
                  end
               end
               ecp_pkg::ST_RACK: begin
                  if (pinS_r.nAck) begin
                     state_r <= ecp_pkg::ST_IDLE;
                  end
               end
               default: state_r <= ecp_pkg::ST_IDLE;
            endcase
         end
      end
   end

   // ---------------------------------------------
   // printer pin drivers
   // ---------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pdOut <= ecp_pkg::DATA_RST;
         pdOe <= 1'b1;
         nStrobe <= 1'b1;
         nAutoFd <= 1'b1;
         nInit <= 1'b0;
         nSelectIn <= 1'b1;
      end else if (clkEn) begin
         pdOe <= ~dirEff;
         nInit <= dcr_r[ecp_pkg::DCR_INIT];
         nSelectIn <= ~dcr_r[ecp_pkg::DCR_SLIN];
         if (mode == ecp_pkg::MODE_ECP) begin
            nSelectIn <= 1'b1;
         end
         nStrobe <= ~dcr_r[ecp_pkg::DCR_STB];
         nAutoFd <= ~dcr_r[ecp_pkg::DCR_AFD];
         pdOut <= data_r;
         if (mode == ecp_pkg::MODE_TEST) begin
            pdOut <= head.data;
         end
         if (fifoMode) begin
            pdOut <= outEntry_r.data;
            nStrobe <= (state_r != ecp_pkg::ST_FSTB);
            // tag high marks an address/RLE byte, sent with nAutoFd low
            nAutoFd <= ~(outEntry_r.tag && state_r != ecp_pkg::ST_IDLE &&
                         state_r != ecp_pkg::ST_RREQ && state_r != ecp_pkg::ST_RACK);
            if (dirEff) begin
               nAutoFd <= (state_r != ecp_pkg::ST_RREQ);
            end
         end
      end
   end

   // ---------------------------------------------
   // host read mux
   // ---------------------------------------------
   logic [7:0] rdMux;
   always_comb begin
      rdMux = ecp_pkg::UNMAPPED_RD;
      if (sel1) begin
         case (ofs)
            ecp_pkg::OFS_DATA: begin
               if (mode == ecp_pkg::MODE_STD) begin
                  rdMux = data_r;
               end else if (mode == ecp_pkg::MODE_BYTE) begin
                  rdMux = dirEff ? pinS_r.pd : data_r;
               end
            end
            ecp_pkg::OFS_STAT: begin
               rdMux = {~pinS_r.busy, pinS_r.nAck, pinS_r.pError,
                        pinS_r.select, pinS_r.nFault, ecp_pkg::DSR_LOW_ONES};
            end
            ecp_pkg::OFS_CTRL: begin
               rdMux = {ecp_pkg::DCR_TOP_ONES, dcr_r};
            end
            default: rdMux = ecp_pkg::UNMAPPED_RD;
         endcase
      end else if (sel2) begin
         case (ofs)
            ecp_pkg::OFS_DATA: begin
               if (mode == ecp_pkg::MODE_CFG) begin
                  rdMux = ecp_pkg::CFGA_VALUE;
               end else if (mode == ecp_pkg::MODE_TEST) begin
                  rdMux = empty ? lastRd_r : head.data;
               end else if (mode == ecp_pkg::MODE_ECP && dirEff) begin
                  rdMux = head.data;
               end
            end
            ecp_pkg::OFS_STAT: begin
               if (mode == ecp_pkg::MODE_CFG) begin
                  rdMux = {1'b0, irqReq, 6'h00};
               end
            end
            ecp_pkg::OFS_CTRL: begin
               rdMux = {mode, ecrLow_r[4:2], full, empty};
            end
            default: rdMux = ecp_pkg::UNMAPPED_RD;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hostRdData <= ecp_pkg::UNMAPPED_RD;
      end else if (clkEn && rdStb) begin
         hostRdData <= rdMux;
      end
   end

   assign hostRdOe = ~busS_r.iorN & ~iorD_r & (sel1 | sel2);
endmodule

//--- test/ecp_port_monitor.sv
`timescale 1ns/1ps
module ecp_port_monitor (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   // host bus
   input wire ecp_pkg::ecp_bus_s hostBus,
   input wire logic [7:0] hostRdData,
   input wire logic hostRdOe,
   input wire logic irqReq,
   // printer pins
   input wire ecp_pkg::ecp_pins_s pinIn,
   input wire logic [7:0] pdOut,
   input wire logic pdOe,
   input wire logic nStrobe,
   input wire logic nAutoFd,
   input wire logic nInit,
   input wire logic nSelectIn
);
   // ---------------------------------------------
   // helper logic
   // ---------------------------------------------
   logic [3:0] sinceEdge;
   logic prevAck, prevFault, ctrlSel, statSel;
   assign ctrlSel = !hostBus.base1SelN && hostBus.addr == 2'h2;
   assign statSel = !hostBus.base1SelN && hostBus.addr == 2'h1;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // saturates so a long quiet spell never wraps back into a false cause
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sinceEdge <= 4'hf;
         prevAck <= 1'b1;
         prevFault <= 1'b1;
      end else begin
         prevAck <= pinIn.nAck;
         prevFault <= pinIn.nFault;
         if ((pinIn.nAck && !prevAck) || (!pinIn.nFault && prevFault))
            sinceEdge <= 4'h0;
         else if (sinceEdge != 4'hf)
            sinceEdge <= sinceEdge + 4'h1;
      end
   end
   // ---------------------------------------------
   // properties
   // ---------------------------------------------
   property p_rst_out;
      $rose(rst_n) |-> !nInit && nSelectIn && nStrobe && nAutoFd;
   endproperty
   a_rst_out: assert property (p_rst_out)
      else $error("printer outputs not at reset levels");
   property p_ctrl_low;
      $rose(hostBus.iowN) && ctrlSel |->
         ##[2:5] (nStrobe == !hostBus.data[0] && nAutoFd == !hostBus.data[1]);
   endproperty
   a_ctrl_low: assert property (p_ctrl_low)
      else $error("strobe or autofeed does not follow control write");
   property p_ctrl_sel;
      $rose(hostBus.iowN) && ctrlSel |->
         ##[2:5] (nSelectIn == !hostBus.data[3] && nInit == hostBus.data[2]);
   endproperty
   a_ctrl_sel: assert property (p_ctrl_sel)
      else $error("select or init does not follow control write");
   property p_busy_bit;
      $fell(hostBus.iorN) && statSel |-> ##4 hostRdData[7] == !pinIn.busy;
   endproperty
   a_busy_bit: assert property (p_busy_bit)
      else $error("status bit 7 not inverse of busy");
   property p_stat_bits;
      $fell(hostBus.iorN) && statSel |-> ##4 hostRdData[6:3] ==
         {pinIn.nAck, pinIn.pError, pinIn.select, pinIn.nFault};
   endproperty
   a_stat_bits: assert property (p_stat_bits)
      else $error("status bits 6 to 3 wrong");
   property p_low_ones;
      $fell(hostBus.iorN) && statSel |-> ##4 hostRdData[2:0] == 3'h7;
   endproperty
   a_low_ones: assert property (p_low_ones)
      else $error("status bits 2 to 0 not ones");
   property p_dcr_top;
      $fell(hostBus.iorN) && ctrlSel |-> ##4 hostRdData[7:6] == 2'h3;
   endproperty
   a_dcr_top: assert property (p_dcr_top)
      else $error("control bits 7 to 6 not ones");
   property p_irq_cause;
      irqReq |-> sinceEdge <= 4'h7;
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt without a recent pin edge");
   property p_stb_busy;
      $fell(nStrobe) |-> !$past(pinIn.busy, 3);
   endproperty
   a_stb_busy: assert property (p_stb_busy)
      else $error("strobe asserted while busy high");
   property p_rd_oe;
      hostRdOe |-> !$past(hostBus.iorN) || !$past(hostBus.iorN, 2) || !$past(hostBus.iorN, 3);
   endproperty
   a_rd_oe: assert property (p_rd_oe)
      else $error("read drive without a read strobe");
endmodule
bind ecp_parallel_port ecp_port_monitor i_mon (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
   .hostBus(hostBus), .hostRdData(hostRdData), .hostRdOe(hostRdOe), .irqReq(irqReq),
   .pinIn(pinIn), .pdOut(pdOut), .pdOe(pdOe), .nStrobe(nStrobe), .nAutoFd(nAutoFd),
   .nInit(nInit), .nSelectIn(nSelectIn));

//--- test/ecp_peripheral_model.sv
`timescale 1ns/1ps
module ecp_peripheral_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // host printer outputs
   input wire logic nStrobe,
   input wire logic nAutoFd,
   input wire logic nInit,
   input wire logic nSelectIn,
   input wire logic [7:0] pdOut,
   // bench control
   input wire logic slow,
   input wire logic [3:0] revCount,
   input wire logic [7:0] revSeed,
   // peripheral pins and log
   output ecp_pkg::ecp_pins_s pins,
   output ecp_pkg::ecp_entry_s got [16],
   output int fwdCnt,
   output logic [3:0] revCnt
);
   logic busyQ, nAckQ, drv;
   logic [7:0] pdQ, rel = 8'h00;
   // pError held low: bus ownership always acknowledged back to the host
   assign pins = {busyQ, nAckQ, 3'b011, drv ? pdQ : rel};
   // a released bus keeps changing so a stale byte is never mistaken for data
   always @(posedge mclk) rel <= ~pins.pd;
   initial begin
      busyQ = 1'b0;
      nAckQ = 1'b1;
      drv = 1'b0;
      pdQ = 8'h00;
      fwdCnt = 0;
      revCnt = 4'h0;
      wait (rst_n);
      forever begin
         @(posedge mclk);
         if (!nStrobe) begin
            repeat (slow ? 5 : 1) @(posedge mclk);
            got[fwdCnt % 16] = {!nAutoFd, pdOut};
            fwdCnt = fwdCnt + 1;
            busyQ <= 1'b1;
            while (!nStrobe) @(posedge mclk);
            repeat (slow ? 5 : 1) @(posedge mclk);
            busyQ <= 1'b0;
         end else if (!nAutoFd && !nInit && nSelectIn && revCnt < revCount) begin
            drv <= 1'b1;
            pdQ <= revSeed + {4'h0, revCnt};
            busyQ <= 1'b1;
            @(posedge mclk);
            nAckQ <= 1'b0;
            while (!nAutoFd) @(posedge mclk);
            nAckQ <= 1'b1;
            drv <= 1'b0;
            busyQ <= 1'b0;
            revCnt = revCnt + 4'h1;
         end
      end
   end
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
   // ---------------------------------------------
   // signals
   // ---------------------------------------------
   logic mclk, rst_n, manual, slow, oe, hostRdOe, irqReq, pdOe;
   logic nStrobe, nAutoFd, nInit, nSelectIn;
   logic [3:0] revCount, revCnt;
   logic [4:0] p;
   logic [7:0] v, hostRdData, pdOut;
   logic [2:0] modeTab [6];
   ecp_pkg::ecp_bus_s hostBus;
   ecp_pkg::ecp_pins_s pinIn, manPins, perPins;
   ecp_pkg::ecp_entry_s got [16];
   ecp_pkg::ecp_entry_s ex [2];
   int fwdCnt, miscompares, nChecks, irqCnt, base, i, j, k;
   localparam logic [7:0] REV_SEED = 8'h5a;
   // outside manual mode the design drives PD whenever its enable is up, else the peripheral's level shows
   assign pinIn = manual ? manPins : {perPins[12:8], pdOe ? pdOut : perPins.pd};
   ecp_parallel_port i_dut (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1), .hostBus(hostBus),
      .hostRdData(hostRdData), .hostRdOe(hostRdOe), .irqReq(irqReq), .pinIn(pinIn),
      .pdOut(pdOut), .pdOe(pdOe), .nStrobe(nStrobe), .nAutoFd(nAutoFd), .nInit(nInit),
      .nSelectIn(nSelectIn));
   ecp_peripheral_model i_per (.mclk(mclk), .rst_n(rst_n), .nStrobe(nStrobe),
      .nAutoFd(nAutoFd), .nInit(nInit), .nSelectIn(nSelectIn), .pdOut(pdOut), .slow(slow),
      .revCount(revCount), .revSeed(REV_SEED), .pins(perPins), .got(got), .fwdCnt(fwdCnt),
      .revCnt(revCnt));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) if (irqReq === 1'b1) irqCnt <= irqCnt + 1;
   // ---------------------------------------------
   // tasks
   // ---------------------------------------------
   task chk(input string what, input logic [7:0] e, input logic [7:0] g);
      nChecks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   // strobes held 7 cycles active and 6 inactive: covers the two-flop sync plus decode
   task acc(input logic wr, input logic b2, input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      hostBus <= {!wr, wr, b2, !b2, a, d};
      repeat (6) @(posedge mclk);
      #1;
      v = hostRdData;
      oe = hostRdOe;
      @(posedge mclk);
      hostBus <= {2'b11, b2, !b2, a, d};
      repeat (6) @(posedge mclk);
      hostBus <= {4'hf, 10'h000};
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task wr(input logic b2, input logic [1:0] a, input logic [7:0] d);
      acc(1'b1, b2, a, d);
   endtask
   task rdc(input string what, input logic b2, input logic [1:0] a, input logic [7:0] m, e);
      acc(1'b0, b2, a, 8'h00);
      chk(what, e & m, v & m);
      chk("rdOe", 8'h01, {7'h0, oe});
   endtask
   task md(input logic [2:0] m);
      wr(1'b1, 2'h2, {m, 5'h00});
   endtask
   task pins4(input logic [3:0] e);
      chk("pins", {4'h0, e}, {4'h0, nStrobe, nAutoFd, nInit, nSelectIn});
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", nChecks, miscompares);
      if (miscompares == 0 && nChecks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      $display("ERROR watchdog expected done seen hang");
      tally_and_finish;
   end
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      hostBus = {4'hf, 10'h000};
      rst_n = 1'b0;
      manual = 1'b0;
      slow = 1'b0;
      revCount = 4'h0;
      manPins = 13'h0b00;
      modeTab = '{ecp_pkg::MODE_STD, ecp_pkg::MODE_BYTE, ecp_pkg::MODE_COMPAT_FIFO_PORT,
         ecp_pkg::MODE_ECP, ecp_pkg::MODE_TEST, ecp_pkg::MODE_CFG};
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      #1;
      pins4(4'b1101);
      rdc("data", 1'b0, 2'h0, 8'hff, 8'h00);
      rdc("dcr", 1'b0, 2'h2, 8'hff, 8'hc0);
      rdc("ecr", 1'b1, 2'h2, 8'he0, 8'h00);
      $display("done: reset");
      for (i = 0; i < 4; i++) begin
         wr(1'b0, 2'h2, 8'h01 << i);
         pins4(4'b1101 ^ (4'b1000 >> i));
      end
      wr(1'b0, 2'h2, 8'hff);
      rdc("dcr", 1'b0, 2'h2, 8'hff, 8'hdf);
      chk("pdOe", 8'h01, {7'h0, pdOe});
      md(ecp_pkg::MODE_BYTE);
      wr(1'b0, 2'h2, 8'h20);
      rdc("dcr", 1'b0, 2'h2, 8'hff, 8'he0);
      chk("pdOe", 8'h00, {7'h0, pdOe});
      wr(1'b0, 2'h2, 8'h00);
      md(ecp_pkg::MODE_STD);
      wr(1'b0, 2'h0, 8'ha5);
      chk("pdOut", 8'ha5, pdOut);
      rdc("data", 1'b0, 2'h0, 8'hff, 8'ha5);
      $display("done: control and data");
      wr(1'b0, 2'h2, 8'h0c);
      for (i = 0; i < 6; i++) begin
         md(modeTab[i]);
         rdc("ecr", 1'b1, 2'h2, 8'he0, {modeTab[i], 5'h00});
         rdc("dsr", 1'b0, 2'h1, 8'hff, 8'hdf);
         rdc("dcr", 1'b0, 2'h2, 8'hff, 8'hcc);
      end
      rdc("cfgA", 1'b1, 2'h0, 8'hff, 8'h10);
      md(ecp_pkg::MODE_TEST);
      wr(1'b1, 2'h0, 8'h3c);
      rdc("testFifo", 1'b1, 2'h0, 8'hff, 8'h3c);
      $display("done: modes");
      manual <= 1'b1;
      for (i = 0; i < 2; i++) begin
         p = i[0] ? 5'b01010 : 5'b10101;
         manPins <= {p, 8'h00};
         repeat (4) @(posedge mclk);
         rdc("dsr", 1'b0, 2'h1, 8'hff, {~p[4], p[3:0], 3'h7});
      end
      manPins <= 13'h0b00;
      md(ecp_pkg::MODE_STD);
      for (i = 0; i < 2; i++) begin
         wr(1'b0, 2'h2, i[0] ? 8'h00 : 8'h10);
         base = irqCnt;
         manPins.nAck <= 1'b0;
         repeat (6) @(posedge mclk);
         manPins.nAck <= 1'b1;
         repeat (12) @(posedge mclk);
         chk("irqCount", i[0] ? 8'h00 : 8'h01, 8'(irqCnt - base));
      end
      manual <= 1'b0;
      $display("done: status and interrupt");
      wr(1'b0, 2'h2, 8'h0c);
      md(ecp_pkg::MODE_ECP);
      chk("nSelectIn", 8'h01, {7'h0, nSelectIn});
      slow <= 1'b1;
      base = fwdCnt;
      ex[0] = {1'b1, 8'h81};
      ex[1] = {1'b0, 8'h42};
      // address port only while direction is forward
      for (j = 0; j < 2; j++) wr(j[0], 2'h0, ex[j].data);
      for (k = 0; k < 500 && fwdCnt < base + 2; k++) @(posedge mclk);
      for (j = 0; j < 2; j++) begin
         chk("fwdByte", ex[j].data, got[(base + j) % 16].data);
         chk("fwdTag", {7'h0, ex[j].tag}, {7'h0, got[(base + j) % 16].tag});
      end
      chk("nSelectIn", 8'h01, {7'h0, nSelectIn});
      $display("done: forward");
      md(ecp_pkg::MODE_BYTE);
      wr(1'b0, 2'h2, 8'h20);
      slow <= 1'b0;
      revCount <= 4'h2;
      md(ecp_pkg::MODE_ECP);
      for (k = 0; k < 500 && revCnt < 4'h2; k++) @(posedge mclk);
      chk("pdOe", 8'h00, {7'h0, pdOe});
      for (j = 0; j < 2; j++) rdc("revByte", 1'b1, 2'h0, 8'hff, REV_SEED + 8'(j));
      $display("done: reverse");
      tally_and_finish;
   end
endmodule
